// ### design/ltd_datapath.sv
// Chosen here: the register offsets and the strobed register port.
module ltd_datapath
#(
	parameter int WIDTH = ltd_pkg::WIDTH,
	parameter int DEPTH = ltd_pkg::QUEUE_DEPTH
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [ltd_pkg::ROUTE_IN-1:0] route_in,
	output logic [ltd_pkg::ROUTE_OUT-1:0] route_out,
	input wire logic [7:0] status_in,
	output logic [7:0] control_out,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_in_routed,
	input wire logic [7:0] pin_out_raw,
	output logic [7:0] pin_out,
	output logic [3:0] sub_clk_en,
	input wire ltd_pkg::ltd_chain_type chain_prev,
	output ltd_pkg::ltd_chain_type chain_next
);
	initial
	begin
		if (WIDTH != 8 || DEPTH < 2 || DEPTH > 16)
			$error("ltd_datapath: unsupported width or depth");
	end
	localparam int PW = $clog2(DEPTH);
	logic [7:0] acc [2];
	logic [7:0] opr [2];
	logic [7:0] cmp_mask [2];
	logic [7:0] poly, msb_sel, out_mask, qcfg, clken, sync_cfg;
	logic [7:0] outsel [3];
	logic [7:0] latch_cfg, status_hold, control, cfg_stage;
	logic [ltd_pkg::CFG_BITS-1:0] cfg_ram [ltd_pkg::CFG_WORDS];
	logic [7:0] qmem [2][DEPTH];
	logic [PW-1:0] qwp [2];
	logic [PW-1:0] qrp [2];
	logic [PW:0] qcnt [2];
	logic q_empty [2];
	logic q_full [2];
	logic carry_reg, shift_reg;
	logic [7:0] sync1, sync2, pin_pipe;
	logic [ltd_pkg::ROUTE_OUT-1:0] route_reg;
	ltd_pkg::ltd_cfg_type cfg;
	logic dp_en, sc_en;
	logic [7:0] op_a, op_b, alu, shifted, result, msb_mask;
	logic [8:0] sum;
	logic carry_in, carry_out, shift_out, ovf;
	logic cmp_eq0, cmp_lt0, cmp_eq1, cmp_lt1, zero_det, ones_det;
	logic [ltd_pkg::NCOND-1:0] cond;
	logic q_bus_wr [2];
	logic q_bus_rd [2];
	logic q_int_wr [2];
	logic q_int_rd [2];
	logic [7:0] q_head [2];
	logic [7:0] q_wdata;
	logic [7:0] status_now;

	function automatic logic [7:0] sel_reg(input logic [1:0] s, input logic [7:0] a0,
		input logic [7:0] a1, input logic [7:0] d0, input logic [7:0] d1);
		case (s)
			2'h0: sel_reg = a0;
			2'h1: sel_reg = a1;
			2'h2: sel_reg = d0;
			default: sel_reg = d1;
		endcase
	endfunction

	assign dp_en = clken[ltd_pkg::CLKEN_DP];
	assign sc_en = clken[ltd_pkg::CLKEN_SC];
	assign sub_clk_en = clken[3:0];
	assign cfg = ltd_pkg::ltd_cfg_type'(cfg_ram[route_in[2:0]]);
	assign op_a = sel_reg(cfg.src_a, acc[0], acc[1], opr[0], opr[1]);
	assign op_b = sel_reg(cfg.src_b, acc[0], acc[1], opr[0], opr[1]);
	assign carry_in = cfg.carry_sel ? carry_reg : chain_prev.carry;
	assign msb_mask = 8'((9'h002 << msb_sel[2:0]) - 9'h001);

	always_comb
	begin
		sum = 9'h000;
		alu = 8'h00;
		case (cfg.op)
			ltd_pkg::LTD_OP_INC: sum = {1'b0, op_a} + 9'h001;
			ltd_pkg::LTD_OP_DEC: sum = {1'b0, op_a} - 9'h001;
			ltd_pkg::LTD_OP_ADD: sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, carry_in};
			ltd_pkg::LTD_OP_SUB: sum = {1'b0, op_a} - {1'b0, op_b};
			ltd_pkg::LTD_OP_AND: sum = {1'b0, op_a & op_b};
			ltd_pkg::LTD_OP_OR: sum = {1'b0, op_a | op_b};
			ltd_pkg::LTD_OP_XOR: sum = {1'b0, op_a ^ op_b};
			default: sum = {1'b0, op_a};
		endcase
		alu = sum[7:0] & msb_mask;
		carry_out = sum[msb_sel[2:0] + 4'h1];
		ovf = (op_a[msb_sel[2:0]] == op_b[msb_sel[2:0]]) &&
			(alu[msb_sel[2:0]] != op_a[msb_sel[2:0]]) && (cfg.op == ltd_pkg::LTD_OP_ADD);
	end

	always_comb
	begin
		shifted = alu;
		shift_out = 1'b0;
		if (cfg.crc_en)
		begin
			// One CRC or sequence step
			shift_out = alu[msb_sel[2:0]];
			shifted = (8'(alu << 1) & msb_mask) ^ ((shift_out ^ chain_prev.shift) ?
				(poly & msb_mask) : 8'h00);
		end
		else
		begin
			case (cfg.shift)
				2'h1:
				begin
					shift_out = alu[msb_sel[2:0]];
					shifted = (8'(alu << 1) | {7'h00, route_in[3]}) & msb_mask;
				end
				2'h2:
				begin
					shift_out = alu[0];
					shifted = (alu >> 1) | (route_in[3] ? (msb_mask & ~(msb_mask >> 1)) : 8'h00);
				end
				2'h3: shifted = {alu[3:0], alu[7:4]};
				default: shifted = alu;
			endcase
		end
		result = shifted | out_mask;
	end

	// Comparators
	always_comb
	begin
		cmp_eq0 = ((acc[0] & cmp_mask[0]) == ((cfg.cmp_pair ? acc[1] : opr[0]) & cmp_mask[0]));
		cmp_lt0 = ((acc[0] & cmp_mask[0]) < ((cfg.cmp_pair ? acc[1] : opr[0]) & cmp_mask[0]));
		cmp_eq1 = ((acc[1] & cmp_mask[1]) == ((cfg.cmp_pair ? acc[0] : opr[1]) & cmp_mask[1]));
		cmp_lt1 = ((acc[1] & cmp_mask[1]) < ((cfg.cmp_pair ? acc[0] : opr[1]) & cmp_mask[1]));
		zero_det = ((acc[0] & msb_mask) == 8'h00);
		ones_det = ((acc[0] & msb_mask) == msb_mask);
		cond = {q_full[1], q_empty[1], q_full[0], q_empty[0],
			shift_out, carry_out, ovf, ones_det, zero_det,
			((acc[1] & msb_mask) == 8'h00), ((acc[1] & msb_mask) == msb_mask),
			cmp_lt1, cmp_eq1 & chain_prev.cmp_eq, cmp_lt0, cmp_eq0, shift_reg};
	end

	assign chain_next.carry = carry_out;
	assign chain_next.shift = shift_out;
	assign chain_next.cmp_eq = cmp_eq0;

	// Queue handshakes
	assign q_wdata = cfg.load_sel[1] ? acc[cfg.dest] : result;
	generate
		for (genvar q = 0; q < 2; q++)
		begin : g_queue
			logic is_out;
			logic [4:0] qaddr;
			assign is_out = qcfg[q];
			assign qaddr = (q == 0) ? ltd_pkg::ADDR_QUEUE0 : ltd_pkg::ADDR_QUEUE1;
			assign q_empty[q] = (qcnt[q] == '0);
			assign q_full[q] = (qcnt[q] == (PW+1)'(DEPTH));
			assign q_head[q] = qmem[q][qrp[q]];
			assign q_bus_wr[q] = wr && addr == qaddr && !is_out && !q_full[q];
			assign q_bus_rd[q] = rd && addr == qaddr && is_out && !q_empty[q];
			assign q_int_wr[q] = dp_en && is_out && cfg.queue_wr && !q_full[q];
			assign q_int_rd[q] = dp_en && !is_out && cfg.load_sel == 2'(q + 1) && !q_empty[q];
			always_ff @(posedge clk_sys)
			begin
				if (rst)
				begin
					qwp[q] <= '0;
					qrp[q] <= '0;
					qcnt[q] <= '0;
				end
				else
				begin
					if (q_bus_wr[q] || q_int_wr[q])
					begin
						qmem[q][qwp[q]] <= q_bus_wr[q] ? wdata : q_wdata;
						qwp[q] <= (qwp[q] == PW'(DEPTH - 1)) ? '0 : qwp[q] + 1'b1;
					end
					if (q_bus_rd[q] || q_int_rd[q])
						qrp[q] <= (qrp[q] == PW'(DEPTH - 1)) ? '0 : qrp[q] + 1'b1;
					qcnt[q] <= qcnt[q] + (PW+1)'(q_bus_wr[q] || q_int_wr[q])
						- (PW+1)'(q_bus_rd[q] || q_int_rd[q]);
				end
			end
		end
	endgenerate

	// Accumulators and operand registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			acc[0] <= 8'h00;
			acc[1] <= 8'h00;
			opr[0] <= 8'h00;
			opr[1] <= 8'h00;
		end
		else
		begin
			if (wr && addr == ltd_pkg::ADDR_ACC0)
				acc[0] <= wdata;
			else if (wr && addr == ltd_pkg::ADDR_ACC1)
				acc[1] <= wdata;
			else if (wr && addr == ltd_pkg::ADDR_OPR0)
				opr[0] <= wdata;
			else if (wr && addr == ltd_pkg::ADDR_OPR1)
				opr[1] <= wdata;
			else if (dp_en)
			begin
				if (cfg.load_sel == 2'h1 && q_int_rd[0])
					opr[cfg.dest] <= q_head[0];
				else if (cfg.load_sel == 2'h2 && q_int_rd[1])
					acc[cfg.dest] <= q_head[1];
				else if (cfg.load_sel == 2'h0)
					acc[cfg.dest] <= result;
			end
		end
	end

	// Registered carry and shift
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			carry_reg <= 1'b0;
			shift_reg <= 1'b0;
		end
		else if (dp_en)
		begin
			carry_reg <= carry_out;
			shift_reg <= shift_out;
		end
	end

	// Configuration registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cmp_mask[0] <= ltd_pkg::MASK_RESET;
			cmp_mask[1] <= ltd_pkg::MASK_RESET;
			poly <= 8'h00;
			msb_sel <= ltd_pkg::MSB_RESET;
			out_mask <= 8'h00;
			qcfg <= ltd_pkg::QCFG_RESET;
			clken <= ltd_pkg::CLKEN_RESET;
			outsel[0] <= 8'h10;
			outsel[1] <= 8'h32;
			outsel[2] <= 8'h54;
			sync_cfg <= 8'hFF;
			latch_cfg <= 8'h00;
			control <= 8'h00;
			cfg_stage <= 8'h00;
			for (int i = 0; i < ltd_pkg::CFG_WORDS; i++)
				cfg_ram[i] <= 16'h0000;
		end
		else if (wr)
		begin
			if (addr == ltd_pkg::ADDR_MASK0)
				cmp_mask[0] <= wdata;
			else if (addr == ltd_pkg::ADDR_MASK1)
				cmp_mask[1] <= wdata;
			else if (addr == ltd_pkg::ADDR_POLY)
				poly <= wdata;
			else if (addr == ltd_pkg::ADDR_MSB)
				msb_sel <= {5'h00, wdata[2:0]};
			else if (addr == ltd_pkg::ADDR_OUTMASK)
				out_mask <= wdata;
			else if (addr == ltd_pkg::ADDR_QCFG)
				qcfg <= {6'h00, wdata[1:0]};
			else if (addr == ltd_pkg::ADDR_CTRL && sc_en)
				control <= wdata;
			else if (addr == ltd_pkg::ADDR_STLATCH)
				latch_cfg <= wdata;
			else if (addr == ltd_pkg::ADDR_CLKEN)
				clken <= {4'h0, wdata[3:0]};
			else if (addr == ltd_pkg::ADDR_OUTSEL0)
				outsel[0] <= wdata;
			else if (addr == ltd_pkg::ADDR_OUTSEL1)
				outsel[1] <= wdata;
			else if (addr == ltd_pkg::ADDR_OUTSEL2)
				outsel[2] <= wdata;
			else if (addr == ltd_pkg::ADDR_SYNC)
				sync_cfg <= wdata;
			else if (addr == ltd_pkg::ADDR_CFG_STAGE)
				cfg_stage <= wdata;
			// Low byte staged, high byte write commits the word
			else if (addr[4:3] == ltd_pkg::ADDR_CFG_BASE[4:3])
				cfg_ram[addr[2:0]] <= {wdata, cfg_stage};
		end
	end
	assign control_out = control;

	// Status capture; a new event beats the read clear
	assign status_now = (status_hold & latch_cfg) | status_in;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			status_hold <= 8'h00;
		else if (sc_en)
		begin
			if (rd && addr == ltd_pkg::ADDR_STATUS)
				status_hold <= status_in & latch_cfg;
			else
				status_hold <= (status_hold | status_in) & latch_cfg;
		end
	end

	// Routing outputs
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			route_reg <= '0;
		else
			for (int i = 0; i < ltd_pkg::ROUTE_OUT; i++)
				route_reg[i] <= cond[outsel[i / 2][(i % 2) * 4 +: 4]];
	end
	assign route_out = route_reg;

	// Pin synchronisers and output pipeline
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sync1 <= 8'h00;
			sync2 <= 8'h00;
			pin_pipe <= 8'h00;
		end
		else
		begin
			sync1 <= pin_in;
			sync2 <= sync1;
			pin_pipe <= pin_out_raw;
		end
	end
	assign pin_in_routed = sync_cfg[0] ? sync2 : pin_in;
	assign pin_out = sync_cfg[1] ? pin_pipe : pin_out_raw;

	// Read port
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rdata <= 8'h00;
		else if (rd)
		begin
			if (addr == ltd_pkg::ADDR_ACC0)
				rdata <= acc[0];
			else if (addr == ltd_pkg::ADDR_ACC1)
				rdata <= acc[1];
			else if (addr == ltd_pkg::ADDR_OPR0)
				rdata <= opr[0];
			else if (addr == ltd_pkg::ADDR_OPR1)
				rdata <= opr[1];
			else if (addr == ltd_pkg::ADDR_QUEUE0)
				rdata <= q_empty[0] ? 8'h00 : q_head[0];
			else if (addr == ltd_pkg::ADDR_QUEUE1)
				rdata <= q_empty[1] ? 8'h00 : q_head[1];
			else if (addr == ltd_pkg::ADDR_QSTAT)
				rdata <= {4'h0, q_full[1], q_empty[1], q_full[0], q_empty[0]};
			else if (addr == ltd_pkg::ADDR_STATUS)
				rdata <= status_now;
			else if (addr == ltd_pkg::ADDR_CTRL)
				rdata <= control;
			else if (addr == ltd_pkg::ADDR_QCFG)
				rdata <= qcfg;
			else if (addr == ltd_pkg::ADDR_MSB)
				rdata <= msb_sel;
			else if (addr == ltd_pkg::ADDR_CLKEN)
				rdata <= clken;
			else
				rdata <= 8'h00;
		end
	end
endmodule

// ### design/ltd_pkg.sv
package ltd_pkg;
	localparam int WIDTH = 8;
	localparam int CFG_WORDS = 8;
	localparam int CFG_BITS = 16;
	localparam int QUEUE_DEPTH = 4;
	localparam int ROUTE_IN = 6;
	localparam int ROUTE_OUT = 6;
	// Register indices on the plain port
	localparam logic [4:0] ADDR_ACC0 = 5'h00;
	localparam logic [4:0] ADDR_ACC1 = 5'h01;
	localparam logic [4:0] ADDR_OPR0 = 5'h02;
	localparam logic [4:0] ADDR_OPR1 = 5'h03;
	localparam logic [4:0] ADDR_QUEUE0 = 5'h04;
	localparam logic [4:0] ADDR_QUEUE1 = 5'h05;
	localparam logic [4:0] ADDR_MASK0 = 5'h06;
	localparam logic [4:0] ADDR_MASK1 = 5'h07;
	localparam logic [4:0] ADDR_POLY = 5'h08;
	localparam logic [4:0] ADDR_MSB = 5'h09;
	localparam logic [4:0] ADDR_OUTMASK = 5'h0A;
	localparam logic [4:0] ADDR_QCFG = 5'h0B;
	localparam logic [4:0] ADDR_QSTAT = 5'h0C;
	localparam logic [4:0] ADDR_CTRL = 5'h0D;
	localparam logic [4:0] ADDR_STATUS = 5'h0E;
	localparam logic [4:0] ADDR_STLATCH = 5'h0F;
	localparam logic [4:0] ADDR_CLKEN = 5'h10;
	localparam logic [4:0] ADDR_OUTSEL0 = 5'h11;
	localparam logic [4:0] ADDR_OUTSEL1 = 5'h12;
	localparam logic [4:0] ADDR_OUTSEL2 = 5'h13;
	localparam logic [4:0] ADDR_SYNC = 5'h14;
	localparam logic [4:0] ADDR_CFG_STAGE = 5'h17;
	localparam logic [4:0] ADDR_CFG_BASE = 5'h18;
	// Clock enable bits
	localparam int CLKEN_DP = 0;
	localparam int CLKEN_SC = 1;
	localparam int CLKEN_ARR0 = 2;
	localparam int CLKEN_ARR1 = 3;
	localparam logic [7:0] CLKEN_RESET = 8'h0F;
	// Queue config bits: bit0 queue0 output mode, bit1 queue1 output mode
	localparam logic [7:0] QCFG_RESET = 8'h00;
	localparam logic [7:0] MSB_RESET = 8'h07;
	localparam logic [7:0] MASK_RESET = 8'hFF;
	// Number of selectable conditions
	localparam int NCOND = 16;
	typedef enum logic [2:0]
	{
		LTD_OP_PASS = 3'h0,
		LTD_OP_INC = 3'h1,
		LTD_OP_DEC = 3'h2,
		LTD_OP_ADD = 3'h3,
		LTD_OP_SUB = 3'h4,
		LTD_OP_AND = 3'h5,
		LTD_OP_OR = 3'h6,
		LTD_OP_XOR = 3'h7
	} ltd_op_type;
	// Configuration word layout
	typedef struct packed
	{
		ltd_op_type op;
		logic [1:0] src_a;
		logic [1:0] src_b;
		logic [1:0] shift;
		logic dest;
		logic [1:0] load_sel;
		logic cmp_pair;
		logic carry_sel;
		logic crc_en;
		logic queue_wr;
	} ltd_cfg_type;
	typedef struct packed
	{
		logic carry;
		logic shift;
		logic cmp_eq;
	} ltd_chain_type;
endpackage

// ### test/ltd_route_model.sv
module ltd_route_model
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic event_req,
	input wire logic [6:0] level_bits,
	input wire logic [2:0] step_addr,
	output logic [5:0] route_in,
	output logic [7:0] status_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sequencer picks the configuration word, serial in low
	assign route_in = {3'h0, step_addr};
	// Steady levels plus a one-cycle event on bit 0
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			status_in <= 8'h00;
		else
			status_in <= {level_bits, event_req};
	end
endmodule

// ### test/ltd_datapath_checker.sv
module ltd_datapath_checker
#(
	parameter int DEPTH = 4
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic [ltd_pkg::ROUTE_OUT-1:0] route_out,
	input wire logic [7:0] status_in,
	input wire logic [7:0] control_out,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_in_routed,
	input wire logic [7:0] pin_out_raw,
	input wire logic [7:0] pin_out,
	input wire logic [3:0] sub_clk_en
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	clken_reset_a: assert property ($fell(rst) |-> sub_clk_en == 4'hF)
		else $error("clock enables wrong after reset");
	ctrl_reset_a: assert property ($fell(rst) |-> control_out == 8'h00)
		else $error("control not cleared by reset");
	route_reset_a: assert property ($fell(rst) |-> route_out == 6'h00)
		else $error("routing outputs not cleared by reset");
	ctrl_write_a: assert property (wr && addr == ltd_pkg::ADDR_CTRL
		&& sub_clk_en[ltd_pkg::CLKEN_SC] |=> control_out == $past(wdata))
		else $error("control write lost");
	ctrl_hold_a: assert property (!(wr && addr == ltd_pkg::ADDR_CTRL) |=> $stable(control_out))
		else $error("control changed without write");
	status_ro_a: assert property (rd && addr == ltd_pkg::ADDR_STATUS
		|=> (rdata & $past(status_in)) == $past(status_in))
		else $error("status read misses routing level");
	rdata_hold_a: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without read");
	pin_pipe_a: assert property (pin_out == pin_out_raw || pin_out == $past(pin_out_raw))
		else $error("output pin path neither direct nor one stage");
	pin_sync_a: assert property (pin_in_routed == pin_in || pin_in_routed == $past(pin_in, 2))
		else $error("input pin path neither direct nor two stages");
	qstat_sane_a: assert property (rd && addr == ltd_pkg::ADDR_QSTAT
		|=> !(rdata[0] && rdata[1]) && !(rdata[2] && rdata[3]))
		else $error("queue both empty and full");
endmodule

bind ltd_datapath ltd_datapath_checker #(.DEPTH(DEPTH)) i_checker
(
	.clk_sys(clk_sys),
	.rst(rst),
	.addr(addr),
	.wdata(wdata),
	.wr(wr),
	.rd(rd),
	.rdata(rdata),
	.route_out(route_out),
	.status_in(status_in),
	.control_out(control_out),
	.pin_in(pin_in),
	.pin_in_routed(pin_in_routed),
	.pin_out_raw(pin_out_raw),
	.pin_out(pin_out),
	.sub_clk_en(sub_clk_en)
);

// ### test/programmable_logic_tile_datapath_bench.sv
module programmable_logic_tile_datapath_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst, wr, rd, event_req;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, status_in, control_out, pin_in, pin_in_routed, pin_out_raw, pin_out;
	logic [6:0] level_bits;
	logic [2:0] step_addr;
	logic [5:0] route_in, route_out;
	logic [3:0] sub_clk_en;
	ltd_pkg::ltd_chain_type chain_prev;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	ltd_datapath i_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .route_in(route_in), .route_out(route_out),
		.status_in(status_in), .control_out(control_out), .pin_in(pin_in),
		.pin_in_routed(pin_in_routed), .pin_out_raw(pin_out_raw), .pin_out(pin_out),
		.sub_clk_en(sub_clk_en), .chain_prev(chain_prev), .chain_next());
	ltd_route_model i_model (.clk_sys(clk_sys), .rst(rst), .event_req(event_req),
		.level_bits(level_bits), .step_addr(step_addr), .route_in(route_in),
		.status_in(status_in));
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			final_report();
		end
	end
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		chk8(rdata, exp);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic t_reset;
		chk8({4'h0, sub_clk_en}, 8'h0F);
		chk8({2'h0, route_out}, 8'h00);
		rd_chk(ltd_pkg::ADDR_CLKEN, ltd_pkg::CLKEN_RESET);
		rd_chk(ltd_pkg::ADDR_MSB, ltd_pkg::MSB_RESET);
		rd_chk(ltd_pkg::ADDR_MASK0, 8'h00);
		rd_chk(ltd_pkg::ADDR_QCFG, ltd_pkg::QCFG_RESET);
		rd_chk(ltd_pkg::ADDR_QSTAT, 8'h05);
		bus_wr(ltd_pkg::ADDR_CFG_BASE, 8'h00);
		bus_wr(ltd_pkg::ADDR_CFG_BASE + 5'h01, 8'h00);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 4; i++)
			bus_wr(ltd_pkg::ADDR_ACC0 + 5'(i), 8'hA0 + 8'(i));
		for (int i = 0; i < 4; i++)
			rd_chk(ltd_pkg::ADDR_ACC0 + 5'(i), 8'hA0 + 8'(i));
		rd_chk(5'h15, 8'h00);
	endtask
	task automatic t_cond;
		bus_wr(ltd_pkg::ADDR_OUTSEL1, 8'h87);
		bus_wr(ltd_pkg::ADDR_ACC0, 8'h00);
		settle();
		chk8({6'h0, route_out[3:2]}, 8'h01);
		bus_wr(ltd_pkg::ADDR_ACC0, 8'hFF);
		settle();
		chk8({6'h0, route_out[3:2]}, 8'h02);
	endtask
	task automatic t_queue;
		bus_wr(ltd_pkg::ADDR_OUTSEL0, 8'hDC);
		settle();
		chk8({6'h0, route_out[1:0]}, 8'h01);
		for (int i = 0; i < 5; i++)
			bus_wr(ltd_pkg::ADDR_QUEUE0, 8'h11 + 8'(i));
		rd_chk(ltd_pkg::ADDR_QSTAT, 8'h06);
		settle();
		chk8({6'h0, route_out[1:0]}, 8'h02);
		rd_chk(ltd_pkg::ADDR_QUEUE0, 8'h11);
		rd_chk(ltd_pkg::ADDR_QSTAT, 8'h06);
		bus_wr(ltd_pkg::ADDR_QCFG, 8'h02);
		bus_wr(ltd_pkg::ADDR_QUEUE1, 8'h77);
		rd_chk(ltd_pkg::ADDR_QSTAT, 8'h06);
		rd_chk(ltd_pkg::ADDR_QUEUE1, 8'h00);
	endtask
	task automatic t_ctrl;
		bus_wr(ltd_pkg::ADDR_CTRL, 8'hA5);
		#1;
		chk8(control_out, 8'hA5);
		bus_wr(ltd_pkg::ADDR_CLKEN, 8'h0D);
		bus_wr(ltd_pkg::ADDR_CTRL, 8'h3C);
		#1;
		chk8(control_out, 8'hA5);
		chk8({4'h0, sub_clk_en}, 8'h0D);
		bus_wr(ltd_pkg::ADDR_CLKEN, 8'h0F);
	endtask
	task automatic t_status;
		rd_chk(ltd_pkg::ADDR_STATUS, 8'h50);
		bus_wr(ltd_pkg::ADDR_STATUS, 8'hFF);
		rd_chk(ltd_pkg::ADDR_STATUS, 8'h50);
		bus_wr(ltd_pkg::ADDR_STLATCH, 8'h01);
		@(posedge clk_sys);
		event_req <= 1'b1;
		@(posedge clk_sys);
		event_req <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd_chk(ltd_pkg::ADDR_STATUS, 8'h51);
		rd_chk(ltd_pkg::ADDR_STATUS, 8'h50);
	endtask
	task automatic t_pins;
		bus_wr(ltd_pkg::ADDR_SYNC, 8'h03);
		@(posedge clk_sys);
		pin_in <= 8'h5A;
		pin_out_raw <= 8'hC3;
		@(posedge clk_sys);
		#1;
		chk8(pin_out, 8'hC3);
		chk8(pin_in_routed, 8'h00);
		@(posedge clk_sys);
		#1;
		chk8(pin_in_routed, 8'h5A);
	endtask
	task automatic step(input logic [2:0] w);
		@(posedge clk_sys);
		step_addr <= w;
		@(posedge clk_sys);
		step_addr <= 3'h0;
	endtask
	task automatic t_alu;
		bus_wr(ltd_pkg::ADDR_ACC0, 8'h35);
		bus_wr(ltd_pkg::ADDR_CFG_STAGE, 8'h04);
		bus_wr(ltd_pkg::ADDR_CFG_BASE + 5'h05, 8'h64);
		bus_wr(ltd_pkg::ADDR_CFG_STAGE, 8'hC0);
		bus_wr(ltd_pkg::ADDR_CFG_BASE + 5'h07, 8'hE7);
		step(3'h5);
		rd_chk(ltd_pkg::ADDR_ACC0, 8'hD7);
		step(3'h7);
		rd_chk(ltd_pkg::ADDR_ACC1, 8'h47);
		rd_chk(ltd_pkg::ADDR_ACC0, 8'hD7);
		rd_chk(ltd_pkg::ADDR_OPR1, 8'hA3);
	endtask
	initial
	begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 5'h00;
		wdata = 8'h00;
		event_req = 1'b0;
		level_bits = 7'h28;
		step_addr = 3'h0;
		pin_in = 8'h00;
		pin_out_raw = 8'h00;
		chain_prev = '0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_cond();
		t_queue();
		t_ctrl();
		t_status();
		t_pins();
		t_alu();
		final_report();
	end
endmodule
